/* File: rtl/rsb_status_bank.sv */
// Read-only status register bank of the packet radio.
// Assumes radio, FIFO and output-pin logic drive the status inputs
// synchronously to i_clk_sys; the host reaches it over the register port.
`timescale 1ns/1ns

module rsb_status_bank #(
    parameter int COUNT_W = rsb_pkg::QUEUE_COUNT_W
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic [7:0] i_signal_strength_level,
    input wire logic [4:0] i_radio_state_code,
    input wire logic i_crc_done,
    input wire logic i_crc_match,
    input wire logic i_carrier_sense,
    input wire logic i_clear_channel,
    input wire logic i_sync_found,
    input wire logic i_packet_end,
    input wire logic i_addr_filter_drop,
    input wire logic i_len_filter_drop,
    input wire logic i_gp_output_two,
    input wire logic i_output_two_invert,
    input wire logic i_gp_output_zero,
    input wire logic i_output_zero_invert,
    input wire logic [COUNT_W-1:0] i_tx_byte_count,
    input wire logic i_tx_queue_underrun,
    input wire logic [COUNT_W-1:0] i_rx_byte_count,
    input wire logic i_rx_queue_overrun
);
    typedef struct packed {
        logic [7:0] rdata;
        logic ack;
    } rsb_bank_t;

    rsb_bank_t cur;
    rsb_bank_t next;
    rsb_flag_if fi ();

    logic tag_ok;
    logic [5:0] offs;
    logic gp_two_raw;
    logic gp_zero_raw;
    logic [7:0] val_strength;
    logic [7:0] val_state;
    logic [7:0] val_packet;
    logic [7:0] val_tx;
    logic [7:0] val_rx;
    logic [7:0] read_value;

    // Events handed to the flag tracker
    assign fi.state_code = i_radio_state_code;
    assign fi.crc_done = i_crc_done;
    assign fi.crc_match = i_crc_match;
    assign fi.carrier_sense = i_carrier_sense;
    assign fi.sync_found = i_sync_found;
    assign fi.frame_over = i_packet_end || i_addr_filter_drop
        || i_len_filter_drop;

    rsb_pkt_flags u_flags (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .fi(fi)
    );

    // Pin level arrives after inversion; undo it so software sees the raw level
    assign gp_two_raw = i_gp_output_two ^ i_output_two_invert;
    assign gp_zero_raw = i_gp_output_zero ^ i_output_zero_invert;

    // Address split; both windows alias to one set of registers
    assign tag_ok = rsb_pkg::rsb_tag_ok(i_reg_addr[7:6]);
    assign offs = i_reg_addr[5:0];

    // Register images built from live inputs and tracked flags
    assign val_strength = i_signal_strength_level;
    assign val_state = {3'h0, i_radio_state_code};

    always_comb begin
        val_packet = 8'h00;
        val_packet[rsb_pkg::PKT_CRC_OK_BIT] = fi.crc_ok;
        val_packet[rsb_pkg::PKT_CARRIER_BIT] = fi.carrier_flag;
        val_packet[rsb_pkg::PKT_CLEAR_CHANNEL_BIT] = i_clear_channel;
        val_packet[rsb_pkg::PKT_FRAME_START_BIT] = fi.frame_start_flag;
        val_packet[rsb_pkg::PKT_GP_TWO_BIT] = gp_two_raw;
        val_packet[rsb_pkg::PKT_GP_ZERO_BIT] = gp_zero_raw;
    end

    // Queue levels: underrun and overrun flags on top, counts below
    assign val_tx = {i_tx_queue_underrun, i_tx_byte_count};
    assign val_rx = {i_rx_queue_overrun, i_rx_byte_count};

    // Read decode; unmapped offsets read as zero
    always_comb begin
        read_value = rsb_pkg::RDATA_UNMAPPED;
        if (tag_ok) begin
            case (offs)
                rsb_pkg::REG_SIGNAL_STRENGTH: read_value = val_strength;
                rsb_pkg::REG_RADIO_FSM_STATE: read_value = val_state;
                rsb_pkg::REG_PACKET_STATUS: read_value = val_packet;
                rsb_pkg::REG_TX_QUEUE_LEVEL: read_value = val_tx;
                rsb_pkg::REG_RX_QUEUE_LEVEL: read_value = val_rx;
                default: read_value = rsb_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    // Read data is caught in the access cycle; a write only acknowledges,
    // so software never disturbs the reported state
    always_comb begin
        next = cur;
        next.ack = i_reg_rd || i_reg_wr;
        if (i_reg_rd) begin
            next.rdata = read_value;
        end
    end

    // Bank register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur.rdata <= rsb_pkg::RDATA_RESET;
            cur.ack <= 1'b0;
        end else begin
            cur <= next;
        end
    end

    assign o_reg_rdata = cur.rdata;
    assign o_reg_ack = cur.ack;

    // Checks on the read path and on the packet flags
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    // A read at one offset, either window
    sequence s_read_at(logic [5:0] off);
        i_reg_rd && rsb_pkg::rsb_tag_ok(i_reg_addr[7:6]) && i_reg_addr[5:0] == off;
    endsequence

    // A read at the alias of the signal strength register
    sequence s_read_alias;
        i_reg_rd && i_reg_addr[7:6] == rsb_pkg::TAG_ALIAS
            && i_reg_addr[5:0] == rsb_pkg::REG_SIGNAL_STRENGTH;
    endsequence

    // Sync word then end of that packet, with no new sync
    sequence s_frame_end;
        i_sync_found ##1 (!i_sync_found && i_packet_end);
    endsequence

    // Fresh receive entry through restart without a matching CRC
    sequence s_rx_restart;
        i_radio_state_code == rsb_pkg::ST_RX_RESTART && !(i_crc_done && i_crc_match);
    endsequence

    // Entry into idle from another state
    sequence s_enter_idle;
        i_radio_state_code == rsb_pkg::ST_IDLE
            && $past(i_radio_state_code) != rsb_pkg::ST_IDLE;
    endsequence

    property p_strength_read;
        s_read_at(rsb_pkg::REG_SIGNAL_STRENGTH) |=> o_reg_ack && o_reg_rdata == $past(i_signal_strength_level);
    endproperty
    a_strength_read: assert property (p_strength_read)
        else $error("signal strength read mismatch");

    property p_state_read;
        s_read_at(rsb_pkg::REG_RADIO_FSM_STATE)
            |=> o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[4:0] == $past(i_radio_state_code);
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("radio state read mismatch");

    property p_alias_read;
        s_read_alias |=> o_reg_rdata == $past(i_signal_strength_level);
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("alias read mismatch");

    property p_crc_set;
        (i_crc_done && i_crc_match) |=> fi.crc_ok && o_reg_rdata == $past(o_reg_rdata)
            || fi.crc_ok && $past(i_reg_rd);
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("crc flag not set after match");

    property p_crc_restart;
        s_rx_restart |=> !fi.crc_ok;
    endproperty
    a_crc_restart: assert property (p_crc_restart)
        else $error("crc flag survived receive restart");

    property p_carrier_idle;
        s_enter_idle |=> !fi.carrier_flag;
    endproperty
    a_carrier_idle: assert property (p_carrier_idle)
        else $error("carrier flag not cleared on idle");

    property p_frame_rise;
        i_sync_found |=> fi.frame_start_flag;
    endproperty
    a_frame_rise: assert property (p_frame_rise)
        else $error("frame start not raised on sync");

    property p_frame_fall;
        s_frame_end |=> !fi.frame_start_flag;
    endproperty
    a_frame_fall: assert property (p_frame_fall)
        else $error("frame start not dropped at packet end");

    property p_frame_drop;
        (!i_sync_found && (i_addr_filter_drop || i_len_filter_drop
            || i_radio_state_code == rsb_pkg::ST_RX_OVERRUN)) |=> !fi.frame_start_flag;
    endproperty
    a_frame_drop: assert property (p_frame_drop)
        else $error("frame start held after drop or overflow");

    property p_gp_levels;
        s_read_at(rsb_pkg::REG_PACKET_STATUS)
            |=> o_reg_rdata[2] == $past(i_gp_output_two ^ i_output_two_invert)
            && o_reg_rdata[0] == $past(i_gp_output_zero ^ i_output_zero_invert)
            && o_reg_rdata[1] == 1'b0 && o_reg_rdata[5] == 1'b0;
    endproperty
    a_gp_levels: assert property (p_gp_levels)
        else $error("output level bits wrong");

    property p_tx_level;
        s_read_at(rsb_pkg::REG_TX_QUEUE_LEVEL)
            |=> o_reg_rdata == {$past(i_tx_queue_underrun), $past(i_tx_byte_count)};
    endproperty
    a_tx_level: assert property (p_tx_level)
        else $error("transmit level read mismatch");

    property p_rx_level;
        s_read_at(rsb_pkg::REG_RX_QUEUE_LEVEL)
            |=> o_reg_rdata == {$past(i_rx_queue_overrun), $past(i_rx_byte_count)};
    endproperty
    a_rx_level: assert property (p_rx_level)
        else $error("receive level read mismatch");

    property p_write_inert;
        (i_reg_wr && !i_reg_rd) |=> o_reg_ack && $stable(o_reg_rdata);
    endproperty
    a_write_inert: assert property (p_write_inert)
        else $error("write changed read data");

    property p_unmapped;
        (i_reg_rd && !rsb_pkg::rsb_tag_ok(i_reg_addr[7:6]))
            |=> o_reg_rdata == rsb_pkg::RDATA_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_ack_once;
        !(i_reg_rd || i_reg_wr) |=> !o_reg_ack;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack without access");
endmodule

/* File: pkg/rsb_pkg.sv */
// Constants and shared decode for the radio status register bank.
// Assumes an 8-bit register address whose two top bits select the alias.
package rsb_pkg;

    // Register offsets, low six address bits
    localparam logic [5:0] REG_SIGNAL_STRENGTH = 6'h34;
    localparam logic [5:0] REG_RADIO_FSM_STATE = 6'h35;
    localparam logic [5:0] REG_PACKET_STATUS = 6'h38;
    localparam logic [5:0] REG_TX_QUEUE_LEVEL = 6'h3A;
    localparam logic [5:0] REG_RX_QUEUE_LEVEL = 6'h3B;

    // Top address bits: plain and alias windows
    localparam logic [1:0] TAG_PLAIN = 2'h0;
    localparam logic [1:0] TAG_ALIAS = 2'h3;

    // Packet status bit positions
    localparam int PKT_CRC_OK_BIT = 7;
    localparam int PKT_CARRIER_BIT = 6;
    localparam int PKT_CLEAR_CHANNEL_BIT = 4;
    localparam int PKT_FRAME_START_BIT = 3;
    localparam int PKT_GP_TWO_BIT = 2;
    localparam int PKT_GP_ZERO_BIT = 0;

    // Queue level layout: flag on top, count below
    localparam int QUEUE_FLAG_BIT = 7;
    localparam int QUEUE_COUNT_W = 7;

    // Reset and unmapped-read values of the read path
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // Radio state codes as the radio controller reports them
    typedef enum logic [4:0] {
        ST_SLEEP = 5'h00, ST_IDLE = 5'h01, ST_CRYSTAL_OFF = 5'h02,
        ST_VCO_ON_MC = 5'h03, ST_REG_ON_MC = 5'h04, ST_MANUAL_CAL = 5'h05,
        ST_VCO_ON = 5'h06, ST_REG_ON = 5'h07, ST_START_CAL = 5'h08,
        ST_BW_BOOST = 5'h09, ST_SYNTH_LOCK = 5'h0A, ST_ADC_ON = 5'h0B,
        ST_END_CAL = 5'h0C, ST_RX = 5'h0D, ST_RX_END = 5'h0E,
        ST_RX_RESTART = 5'h0F, ST_TX_TO_RX = 5'h10, ST_RX_OVERRUN = 5'h11,
        ST_SYNTH_ON = 5'h12, ST_TX = 5'h13, ST_TX_END = 5'h14,
        ST_RX_TO_TX = 5'h15, ST_TX_UNDERRUN = 5'h16
    } rsb_state_t;

    // Receive family spans three codes
    function automatic logic rsb_in_rx(input logic [4:0] code);
        return (code == ST_RX) || (code == ST_RX_END) || (code == ST_RX_RESTART);
    endfunction

    // Address lands in the bank, plain or alias
    function automatic logic rsb_tag_ok(input logic [1:0] tag);
        return (tag == TAG_PLAIN) || (tag == TAG_ALIAS);
    endfunction

endpackage

/* File: pkg/rsb_flag_if.sv */
// Carrier between the register bank and its packet flag tracker.
// Assumes both ends share i_clk_sys.
`timescale 1ns/1ns
interface rsb_flag_if;
    logic [4:0] state_code;
    logic crc_done;
    logic crc_match;
    logic carrier_sense;
    logic sync_found;
    logic frame_over;
    logic crc_ok;
    logic carrier_flag;
    logic frame_start_flag;

    modport bank (output state_code, crc_done, crc_match, carrier_sense,
        sync_found, frame_over, input crc_ok, carrier_flag, frame_start_flag);
    modport tracker (input state_code, crc_done, crc_match, carrier_sense,
        sync_found, frame_over, output crc_ok, carrier_flag, frame_start_flag);
endinterface

/* File: rtl/rsb_pkt_flags.sv */
// Packet flag tracker: CRC match, carrier sense and frame start.
// Assumes event inputs are one-cycle pulses on i_clk_sys.
`timescale 1ns/1ns
module rsb_pkt_flags (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    rsb_flag_if.tracker fi
);
    typedef struct packed {
        logic [4:0] prev_state;
        logic crc_ok;
        logic carrier;
        logic frame_start;
    } rsb_flags_t;

    rsb_flags_t cur;
    rsb_flags_t next;
    logic enter_rx;
    logic enter_idle;

    // Edges of the reported radio state
    assign enter_rx = (fi.state_code == rsb_pkg::ST_RX_RESTART)
        || (rsb_pkg::rsb_in_rx(fi.state_code) && !rsb_pkg::rsb_in_rx(cur.prev_state));
    assign enter_idle = (fi.state_code == rsb_pkg::ST_IDLE)
        && (cur.prev_state != rsb_pkg::ST_IDLE);

    // Flag updates; a fresh CRC match or sync beats a same-cycle clear, but idle entry beats carrier sense
    always_comb begin
        next = cur;
        next.prev_state = fi.state_code;
        if (fi.crc_done && fi.crc_match) begin
            next.crc_ok = 1'b1;
        end else if (fi.crc_done || enter_rx) begin
            next.crc_ok = 1'b0;
        end
        next.carrier = enter_idle ? 1'b0 : fi.carrier_sense;
        if (fi.sync_found) begin
            next.frame_start = 1'b1;
        end else if (fi.frame_over || fi.state_code == rsb_pkg::ST_RX_OVERRUN) begin
            next.frame_start = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign fi.crc_ok = cur.crc_ok;
    assign fi.carrier_flag = cur.carrier;
    assign fi.frame_start_flag = cur.frame_start;
endmodule

/* File: verification/rsb_host_model.sv */
// Host controller model for the status bank's register port.
// Assumes the bank takes a strobe on a rising edge and acks one cycle later.
`timescale 1ns/1ns
module rsb_host_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_ack,
    output logic [7:0] o_reg_addr,
    output logic o_reg_rd,
    output logic o_reg_wr
);
    // Port idle at time zero
    initial begin
        o_reg_addr = 8'h00;
        o_reg_rd = 1'b0;
        o_reg_wr = 1'b0;
    end

    // One access, one-cycle strobe; output bits are never polled for lock
    task automatic access(input logic [7:0] addr, input logic wr, output logic [7:0] data,
        output logic ack);
        @(posedge i_clk_sys);
        #1;
        o_reg_addr = addr;
        o_reg_rd = ~wr;
        o_reg_wr = wr;
        @(posedge i_clk_sys);
        #1;
        data = i_reg_rdata;
        ack = i_reg_ack;
        o_reg_rd = 1'b0;
        o_reg_wr = 1'b0;
        o_reg_addr = ~addr; // Scrambled so a stale address never helps
    endtask
endmodule

/* File: verification/rsb_status_bank_test.sv */
// Self-checking bench for the radio status register bank.
// Assumes the host model drives the register port; status inputs come from here.
`timescale 1ns/1ns
module rsb_status_bank_test;
    logic i_clk_sys;
    logic i_sys_rst;
    logic [7:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_rdata;
    logic reg_ack;
    logic [7:0] signal_strength_level;
    logic [4:0] state;
    logic [5:0] ev; // Pulses: crc done, match, sync, end, addr drop, len drop
    logic carrier;
    logic clear_ch;
    logic [3:0] gp; // Pin two, invert two, pin zero, invert zero
    logic [6:0] tx_cnt;
    logic tx_err;
    logic [6:0] rx_cnt;
    logic rx_err;
    int miscompares;
    int num_checks;

    // Free-running 250 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    rsb_status_bank u_rsb_status_bank (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reg_addr(reg_addr),
        .i_reg_rd(reg_rd), .i_reg_wr(reg_wr), .o_reg_rdata(reg_rdata), .o_reg_ack(reg_ack),
        .i_signal_strength_level(signal_strength_level), .i_radio_state_code(state), .i_crc_done(ev[0]), .i_crc_match(ev[1]),
        .i_carrier_sense(carrier), .i_clear_channel(clear_ch), .i_sync_found(ev[2]),
        .i_packet_end(ev[3]), .i_addr_filter_drop(ev[4]), .i_len_filter_drop(ev[5]),
        .i_gp_output_two(gp[3]), .i_output_two_invert(gp[2]), .i_gp_output_zero(gp[1]),
        .i_output_zero_invert(gp[0]), .i_tx_byte_count(tx_cnt), .i_tx_queue_underrun(tx_err),
        .i_rx_byte_count(rx_cnt), .i_rx_queue_overrun(rx_err)
    );

    rsb_host_model u_rsb_host_model (
        .i_clk_sys(i_clk_sys), .i_reg_rdata(reg_rdata), .i_reg_ack(reg_ack),
        .o_reg_addr(reg_addr), .o_reg_rd(reg_rd), .o_reg_wr(reg_wr)
    );

    // Byte and bit comparisons, counted
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Read one register and compare the masked bits
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] data;
        logic ack;
        u_rsb_host_model.access(addr, 1'b0, data, ack);
        check_bit("read ack", 1'b1, ack);
        check_byte($sformatf("register %h", addr), exp & mask, data & mask);
    endtask

    task automatic step_state(input logic [4:0] s);
        @(posedge i_clk_sys);
        #1 state = s;
    endtask

    // One-cycle event pulse; the edge between keeps drivers single-assigned
    task automatic pulse(input logic [5:0] v);
        @(posedge i_clk_sys);
        #1 ev = v;
        @(posedge i_clk_sys);
        #1 ev = 6'h00;
    endtask

    task automatic t_signal_strength_level();
        logic [7:0] vals [4] = '{8'h00, 8'hA5, 8'hFF, 8'h5A};
        foreach (vals[i]) begin
            signal_strength_level = vals[i];
            rd_chk(8'h34, 8'hFF, vals[i]);
            rd_chk(8'hF4, 8'hFF, vals[i]);
        end
    endtask

    task automatic t_states();
        for (int c = 0; c <= 22; c++) begin
            step_state(c[4:0]);
            rd_chk(8'h35, 8'hFF, {3'h0, c[4:0]});
            rd_chk(8'hF5, 8'hFF, {3'h0, c[4:0]});
        end
    endtask

    task automatic t_queues();
        logic [15:0] tab [3] = '{16'hFF00, 16'h00C0, 16'hAAD5};
        foreach (tab[i]) begin
            {tx_err, tx_cnt, rx_err, rx_cnt} = tab[i];
            rd_chk(i[0] ? 8'hFA : 8'h3A, 8'hFF, tab[i][15:8]);
            rd_chk(i[0] ? 8'h3B : 8'hFB, 8'hFF, tab[i][7:0]);
        end
    endtask

    task automatic t_gpio();
        for (int i = 0; i < 16; i++) begin
            gp = i[3:0];
            clear_ch = i[0];
            rd_chk(8'h38, 8'h37, {3'h0, clear_ch, 1'b0, gp[3] ^ gp[2], 1'b0, gp[1] ^ gp[0]});
        end
    endtask

    task automatic t_crc();
        step_state(5'h12);
        pulse(6'h03);
        rd_chk(8'h38, 8'h80, 8'h80);
        pulse(6'h01);
        rd_chk(8'h38, 8'h80, 8'h00);
        pulse(6'h03);
        step_state(5'h0D);
        rd_chk(8'h38, 8'h80, 8'h00);
        pulse(6'h03);
        rd_chk(8'h38, 8'h80, 8'h80);
        step_state(5'h0F);
        rd_chk(8'h38, 8'h80, 8'h00);
    endtask

    task automatic t_carrier();
        step_state(5'h0D);
        carrier = 1'b1;
        rd_chk(8'h38, 8'h40, 8'h40);
        // Carrier still sensed, so only the idle entry can clear the bit
        step_state(5'h01);
        rd_chk(8'h38, 8'h40, 8'h00);
        rd_chk(8'h38, 8'h40, 8'h40);
        carrier = 1'b0;
    endtask

    // Sync raises the flag; each clearing cause is tried in turn
    task automatic t_frame();
        for (int k = 0; k < 4; k++) begin
            step_state(5'h0D);
            pulse(6'h04);
            rd_chk(8'h38, 8'h08, 8'h08);
            if (k < 3) begin
                pulse(6'h08 << k);
            end else begin
                step_state(5'h11);
            end
            rd_chk(8'h38, 8'h08, 8'h00);
        end
        // Sync then packet end on the very next edge
        step_state(5'h0D);
        @(posedge i_clk_sys);
        #1 ev = 6'h04;
        @(posedge i_clk_sys);
        #1 ev = 6'h08;
        @(posedge i_clk_sys);
        #1 ev = 6'h00;
        rd_chk(8'h38, 8'h08, 8'h00);
    endtask

    task automatic t_write();
        logic [7:0] data;
        logic ack;
        signal_strength_level = 8'h3C;
        rd_chk(8'h34, 8'hFF, 8'h3C);
        u_rsb_host_model.access(8'h35, 1'b1, data, ack);
        check_bit("write ack", 1'b1, ack);
        check_byte("data after write", 8'h3C, data);
        rd_chk(8'h34, 8'hFF, 8'h3C);
        rd_chk(8'h74, 8'hFF, 8'h00);
        rd_chk(8'hB4, 8'hFF, 8'h00);
        rd_chk(8'h36, 8'hFF, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence: reset, then every scenario
    initial begin
        miscompares = 0;
        num_checks = 0;
        i_sys_rst = 1'b1;
        {signal_strength_level, state, ev, carrier, clear_ch, gp} = '0;
        {tx_cnt, tx_err, rx_cnt, rx_err} = '0;
        repeat (20) @(posedge i_clk_sys);
        check_byte("reset read data", 8'h00, reg_rdata);
        check_bit("reset ack", 1'b0, reg_ack);
        #1 i_sys_rst = 1'b0;
        t_signal_strength_level();
        t_states();
        t_queues();
        t_gpio();
        t_crc();
        t_carrier();
        t_frame();
        t_write();
        complete_run();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule
